//--- verilog/otpu_pkg.sv
package otpu_pkg;
  // Clock and character timing
  localparam int           CLK_HZ            = 40_000_000;
  localparam int           CLK_NS            = 25;
  localparam int           WORD_W            = 16;
  localparam int           TICK_W            = 24;
  localparam int           SPAN_W            = 20;
  localparam logic [3:0]   BIT_START         = 4'h0;
  localparam logic [3:0]   BIT_PARITY        = 4'h9;
  localparam logic [3:0]   BIT_STOP          = 4'hA;
  localparam logic         LINE_IDLE         = 1'b1;
  localparam int           TURN_BITS         = 7;
  // Sync character: the four falls after the first one span eight bit times
  localparam logic [7:0]   SYNC_BYTE         = 8'h55;
  localparam logic [2:0]   SYNC_LAST_EDGE    = 3'h3;
  localparam int           SYNC_SHIFT        = 3;
  // Inactivity timeout
  localparam int           TIMEOUT_NS        = 1_000_000;
  localparam int           TIMEOUT_CYCLES    = TIMEOUT_NS / CLK_NS;
  localparam int           MIN_TIMEOUT       = 16;
  // Fuse store layout
  localparam int           OTP_BITS          = 128;
  localparam int           USER_LOCK_BIT     = 104;
  localparam int           FACTORY_LOCK_BIT  = 127;
  localparam int           FACTORY_FIRST_BIT = 112;
  localparam logic [7:0]   UNLOCK_KEY_DEFAULT = 8'hA5;
  // Command character and device address map
  localparam int           RNW_BIT           = 7;
  localparam logic [6:0]   ADDR_OTP_LAST     = 7'h0F;
  localparam logic [6:0]   ADDR_ANGLE_LO     = 7'h20;
  localparam logic [6:0]   ADDR_ANGLE_HI     = 7'h21;
  localparam logic [6:0]   ADDR_BURN         = 7'h41;
  localparam logic [6:0]   ADDR_BAUD_LO      = 7'h42;
  localparam logic [6:0]   ADDR_BAUD_HI      = 7'h43;
  localparam logic [6:0]   ADDR_FUNC         = 7'h60;
  localparam logic [15:0]  BIT_PERIOD_RESET  = 16'h0000;
  localparam logic [1:0]   POS_CMD           = 2'h0;
  localparam logic [1:0]   POS_D0            = 2'h1;
  localparam logic [1:0]   POS_D1            = 2'h2;
  // Controller APB map
  localparam int           APB_AW            = 8;
  localparam logic [7:0]   REG_CTRL          = 8'h00;
  localparam logic [7:0]   REG_DATA          = 8'h04;
  localparam logic [7:0]   REG_STAT          = 8'h08;
  localparam logic [7:0]   REG_BAUD          = 8'h0C;
  localparam int           CTRL_SYNC_BIT     = 8;
  localparam int           STAT_BUSY         = 0;
  localparam int           STAT_DONE         = 1;
  localparam int           STAT_PERR         = 2;
  localparam int           STAT_TOUT         = 3;
  localparam int           HOST_BAUD         = 115_200;
  localparam logic [15:0]  HOST_PERIOD_DEFAULT = 16'(CLK_HZ / HOST_BAUD);
  localparam int           HOST_WAIT_BITS    = 16;

  // Line level of bit i of a character: start, data LSB first, even parity, stop
  function automatic logic char_bit(input logic [7:0] b, input logic [3:0] i);
    logic v;
    v = LINE_IDLE;
    if (i == BIT_START) v = ~LINE_IDLE;
    else if (i == BIT_PARITY) v = ^b;
    else if (i < BIT_PARITY) v = b[3'(i - 4'h1)];
    return v;
  endfunction : char_bit
endpackage : otpu_pkg

//--- verilog/otpu_link_if.sv
`timescale 1ns/1ps
interface otpu_link_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;

  // Pulled-up shared wire: low whenever an enabled driver drives low
  assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));

  modport device (input line, output dev_out, output dev_oe);
  modport host   (input line, output host_out, output host_oe);
endinterface : otpu_link_if

//--- verilog/otpu_device.sv
`timescale 1ns/1ps
module otpu_device #(
  parameter logic [otpu_pkg::OTP_BITS-1:0] FUSE_INIT      = '0,
  parameter logic [7:0]                    UNLOCK_KEY     = otpu_pkg::UNLOCK_KEY_DEFAULT,
  parameter int                            TIMEOUT_CYCLES = otpu_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            srst,
  // Shared programming line
  otpu_link_if.device                          link,
  // Sensor side
  input  wire logic [otpu_pkg::WORD_W-1:0]     angle_value,
  output logic      [otpu_pkg::OTP_BITS-1:0]   otp_image,
  output logic                                 functional_mode
);
  import otpu_pkg::*;

  localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);

  // Refuse a timeout too short to span a character gap
  if (TIMEOUT_CYCLES < MIN_TIMEOUT) begin : g_tmo_chk
    $error("otpu_device: TIMEOUT_CYCLES too small");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SYNC = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_RX   = 6'b001000,
    ST_GAP  = 6'b010000,
    ST_TX   = 6'b100000
  } otpu_dev_state_type;

  otpu_dev_state_type    state_r;
  logic [TICK_W-1:0]     tick_r;
  logic [3:0]            bit_r;
  logic [8:0]            shift_r;
  logic [1:0]            pos_r;
  logic [7:0]            cmd_r;
  logic [2:0]            edges_r;
  logic [SPAN_W-1:0]     span_r;
  logic [7:0]            tx_byte_r;
  logic                  tx_second_r;
  logic                  oe_r;
  logic                  line_q_r;
  logic [TMO_W-1:0]      tmo_r;
  logic [OTP_BITS-1:0]   fuse_r;
  logic [OTP_BITS-1:0]   shadow_r;
  logic [WORD_W-1:0]     bit_period_r;
  logic                  manual_r;
  logic                  func_r;
  logic                  fall;
  logic                  any_edge;
  logic                  tmo_hit;
  logic                  rx_tick;
  logic                  char_ok;
  logic                  rx_done;
  logic                  meas_done;
  logic [WORD_W-1:0]     measured;
  logic                  wr_en;
  logic [6:0]            wr_addr;
  logic [7:0]            wr_data;
  logic                  user_lock;
  logic                  factory_lock;
  logic [OTP_BITS-1:0]   burn_mask;
  logic [WORD_W-1:0]     baud_wr_val;
  logic [TICK_W-1:0]     period_ext;
  logic [TICK_W-1:0]     half_period;

  // Readable byte map; unmapped addresses answer zero
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [7:0] v;
    v = '0;
    if (a <= ADDR_OTP_LAST) v = shadow_r[a[3:0]*8 +: 8];
    else if (a == ADDR_ANGLE_LO) v = angle_value[7:0];
    else if (a == ADDR_ANGLE_HI) v = angle_value[15:8];
    else if (a == ADDR_BAUD_LO) v = bit_period_r[7:0];
    else if (a == ADDR_BAUD_HI) v = bit_period_r[15:8];
    return v;
  endfunction : rd_byte

  // Line edge detection; line is synchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (srst) line_q_r <= LINE_IDLE;
    else line_q_r <= link.line;
  end

  assign fall        = line_q_r & ~link.line;
  assign any_edge    = line_q_r ^ link.line;
  assign period_ext  = TICK_W'(bit_period_r);
  assign half_period = period_ext >> 1;
  assign rx_tick     = (state_r == ST_RX) && (tick_r == '0);
  assign char_ok     = (link.line == LINE_IDLE) && (shift_r[8] == ^shift_r[7:0]);
  assign rx_done     = rx_tick && (bit_r == BIT_STOP);
  assign meas_done   = (state_r == ST_SYNC) && fall && (edges_r == SYNC_LAST_EDGE);
  assign measured    = WORD_W'((span_r + SPAN_W'(1)) >> SYNC_SHIFT);
  assign tmo_hit     = (tmo_r == TMO_W'(TIMEOUT_CYCLES - 1));

  // Data bytes land at the command address and the one after it
  assign wr_en   = rx_done && char_ok && (pos_r != POS_CMD) && !cmd_r[RNW_BIT];
  assign wr_addr = cmd_r[6:0] + ((pos_r == POS_D1) ? 7'h01 : 7'h00);
  assign wr_data = shift_r[7:0];

  // Inactivity counter; only runs while waiting on the controller
  always_ff @(posedge ref_clk) begin
    if (srst || any_edge || state_r == ST_IDLE || state_r == ST_GAP || state_r == ST_TX) tmo_r <= '0;
    else tmo_r <= tmo_r + TMO_W'(1);
  end

  // Serial engine: sync measurement, receive, turnaround and answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      tick_r      <= '0;
      bit_r       <= BIT_START;
      shift_r     <= '0;
      pos_r       <= POS_CMD;
      cmd_r       <= '0;
      edges_r     <= '0;
      span_r      <= '0;
      tx_byte_r   <= '0;
      tx_second_r <= 1'b0;
      oe_r        <= 1'b0;
    end else if (func_r || tmo_hit) begin
      state_r <= ST_IDLE;
      oe_r    <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          pos_r <= POS_CMD;
          if (fall && manual_r) begin
            state_r <= ST_RX;
            tick_r  <= half_period;
            bit_r   <= BIT_START;
          end else if (fall) begin
            state_r <= ST_SYNC;
            edges_r <= '0;
            span_r  <= '0;
          end
        end
        ST_SYNC: begin
          span_r <= span_r + SPAN_W'(1);
          if (fall) edges_r <= edges_r + 3'h1;
          if (meas_done) state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (fall) begin
            state_r <= ST_RX;
            tick_r  <= half_period;
            bit_r   <= BIT_START;
          end
        end
        ST_RX: begin
          if (tick_r != '0) tick_r <= tick_r - TICK_W'(1);
          else if (bit_r == BIT_START && link.line == LINE_IDLE) state_r <= ST_IDLE;
          else if (bit_r != BIT_STOP) begin
            if (bit_r != BIT_START) shift_r <= {link.line, shift_r[8:1]};
            bit_r  <= bit_r + 4'h1;
            tick_r <= period_ext - TICK_W'(1);
          end else if (!char_ok) state_r <= ST_IDLE;
          else if (pos_r == POS_CMD) begin
            cmd_r <= shift_r[7:0];
            if (shift_r[RNW_BIT]) begin
              state_r     <= ST_GAP;
              tick_r      <= TICK_W'(TURN_BITS) * period_ext + half_period;
              tx_byte_r   <= rd_byte(shift_r[6:0]);
              tx_second_r <= 1'b0;
            end else begin
              state_r <= ST_WAIT;
              pos_r   <= POS_D0;
            end
          end else if (pos_r == POS_D0) begin
            state_r <= ST_WAIT;
            pos_r   <= POS_D1;
          end else state_r <= ST_IDLE;
        end
        ST_GAP: begin
          if (tick_r != '0) tick_r <= tick_r - TICK_W'(1);
          else begin
            state_r <= ST_TX;
            bit_r   <= BIT_START;
            tick_r  <= period_ext - TICK_W'(1);
            oe_r    <= ~char_bit(tx_byte_r, BIT_START);
          end
        end
        ST_TX: begin
          if (tick_r != '0) tick_r <= tick_r - TICK_W'(1);
          else if (bit_r != BIT_STOP) begin
            bit_r  <= bit_r + 4'h1;
            tick_r <= period_ext - TICK_W'(1);
            oe_r   <= ~char_bit(tx_byte_r, bit_r + 4'h1);
          end else if (!tx_second_r) begin
            tx_second_r <= 1'b1;
            tx_byte_r   <= rd_byte(cmd_r[6:0] + 7'h01);
            bit_r       <= BIT_START;
            tick_r      <= period_ext - TICK_W'(1);
            oe_r        <= ~char_bit(rd_byte(cmd_r[6:0] + 7'h01), BIT_START);
          end else begin
            state_r <= ST_IDLE;
            oe_r    <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  // Only ever pulls low: output level fixed, enable carries the data
  assign link.dev_out = ~LINE_IDLE;
  assign link.dev_oe  = oe_r;

  // Lock bits live in the fuse cells themselves
  assign user_lock    = fuse_r[USER_LOCK_BIT];
  assign factory_lock = fuse_r[FACTORY_LOCK_BIT];
  assign burn_mask    = {{(OTP_BITS-FACTORY_FIRST_BIT){~factory_lock}},
                         {FACTORY_FIRST_BIT{~user_lock}}};
  assign baud_wr_val  = (wr_addr == ADDR_BAUD_LO) ? {bit_period_r[15:8], wr_data}
                                                  : {wr_data, bit_period_r[7:0]};

  // Fuse cells: burning can only add ones
  always_ff @(posedge ref_clk) begin
    if (srst) fuse_r <= FUSE_INIT;
    else if (wr_en && wr_addr == ADDR_BURN && wr_data == UNLOCK_KEY)
      fuse_r <= fuse_r | (shadow_r & burn_mask);
  end

  // Working copy; factory bytes also need the factory lock open
  always_ff @(posedge ref_clk) begin
    if (srst) shadow_r <= FUSE_INIT;
    else if (wr_en && wr_addr <= ADDR_OTP_LAST && !user_lock &&
             (32'(wr_addr) * 8 < FACTORY_FIRST_BIT || !factory_lock))
      shadow_r[wr_addr[3:0]*8 +: 8] <= wr_data;
  end

  // Bit period: a nonzero manual value overrides later measurements
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bit_period_r <= BIT_PERIOD_RESET;
      manual_r     <= 1'b0;
    end else if (wr_en && (wr_addr == ADDR_BAUD_LO || wr_addr == ADDR_BAUD_HI)) begin
      bit_period_r <= baud_wr_val;
      manual_r     <= (baud_wr_val != '0);
    end else if (meas_done && !manual_r) bit_period_r <= measured;
  end

  // Mode: a user-locked part leaves communication one cycle after reset
  always_ff @(posedge ref_clk) begin
    if (srst) func_r <= 1'b0;
    else if (user_lock || (wr_en && wr_addr == ADDR_FUNC && wr_data == UNLOCK_KEY))
      func_r <= 1'b1;
  end

  assign otp_image       = shadow_r;
  assign functional_mode = func_r;
endmodule : otpu_device

//--- verilog/otpu_host.sv
`timescale 1ns/1ps
module otpu_host #(
  parameter int APB_AW = otpu_pkg::APB_AW
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Shared programming line
  otpu_link_if.host              link
);
  import otpu_pkg::*;

  if (APB_AW < 4) begin : g_aw_chk
    $error("otpu_host: APB_AW too small");
  end

  typedef enum logic [3:0] {
    HS_IDLE   = 4'b0001,
    HS_TX     = 4'b0010,
    HS_LISTEN = 4'b0100,
    HS_RX     = 4'b1000
  } otpu_host_state_type;

  otpu_host_state_type state_r;
  logic [TICK_W-1:0]   tick_r;
  logic [3:0]          bit_r;
  logic [1:0]          idx_r;
  logic [8:0]          shift_r;
  logic [8:0]          ctrl_r;
  logic [WORD_W-1:0]   wdata_r;
  logic [WORD_W-1:0]   rdata_r;
  logic [WORD_W-1:0]   period_r;
  logic                done_r;
  logic                perr_r;
  logic                tout_r;
  logic                oe_r;
  logic                out_r;
  logic                line_q_r;
  logic [31:0]         prdata_r;
  logic                acc;
  logic                mapped;
  logic                start;
  logic                fall;
  logic [TICK_W-1:0]   period_ext;
  logic [TICK_W-1:0]   wait_limit;
  logic [7:0]          cur_char;
  logic [1:0]          last_idx;

  // Outgoing character by index: sync, command, low data, high data
  function automatic logic [7:0] host_char(input logic [1:0] i);
    logic [7:0] v;
    v = SYNC_BYTE;
    if (i == 2'h1) v = ctrl_r[7:0];
    else if (i == 2'h2) v = wdata_r[7:0];
    else if (i == 2'h3) v = wdata_r[15:8];
    return v;
  endfunction : host_char

  // Zero-wait slave; new orders are refused while busy
  assign acc     = psel & penable;
  assign mapped  = (paddr == REG_CTRL) || (paddr == REG_DATA) || (paddr == REG_STAT) || (paddr == REG_BAUD);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign start   = acc & pwrite & (paddr == REG_CTRL) & (state_r == HS_IDLE);
  assign prdata  = prdata_r;

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (srst) prdata_r <= '0;
    else if (psel && !penable) begin
      case (paddr)
        REG_CTRL: prdata_r <= 32'(ctrl_r);
        REG_DATA: prdata_r <= 32'(rdata_r);
        REG_STAT: prdata_r <= 32'({tout_r, perr_r, done_r, state_r != HS_IDLE});
        REG_BAUD: prdata_r <= 32'(period_r);
        default:  prdata_r <= '0;
      endcase
    end
  end

  // Writable configuration
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r   <= '0;
      wdata_r  <= '0;
      period_r <= HOST_PERIOD_DEFAULT;
    end else if (acc && pwrite) begin
      if (start) ctrl_r <= pwdata[8:0];
      if (paddr == REG_DATA && state_r == HS_IDLE) wdata_r <= pwdata[15:0];
      if (paddr == REG_BAUD && state_r == HS_IDLE) period_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) line_q_r <= LINE_IDLE;
    else line_q_r <= link.line;
  end

  assign fall       = line_q_r & ~link.line;
  assign period_ext = TICK_W'(period_r);
  assign wait_limit = TICK_W'(TURN_BITS + HOST_WAIT_BITS) * period_ext;
  assign cur_char   = host_char(idx_r);
  assign last_idx   = ctrl_r[RNW_BIT] ? 2'h1 : 2'h3;

  // Sender and answer receiver
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= HS_IDLE;
      tick_r  <= '0;
      bit_r   <= BIT_START;
      idx_r   <= '0;
      shift_r <= '0;
      rdata_r <= '0;
      done_r  <= 1'b0;
      perr_r  <= 1'b0;
      tout_r  <= 1'b0;
      oe_r    <= 1'b0;
      out_r   <= LINE_IDLE;
    end else begin
      case (state_r)
        HS_IDLE: begin
          if (start) begin
            state_r <= HS_TX;
            idx_r   <= pwdata[CTRL_SYNC_BIT] ? 2'h0 : 2'h1;
            bit_r   <= BIT_START;
            tick_r  <= period_ext - TICK_W'(1);
            oe_r    <= 1'b1;
            out_r   <= ~LINE_IDLE;
            done_r  <= 1'b0;
            perr_r  <= 1'b0;
            tout_r  <= 1'b0;
          end
        end
        HS_TX: begin
          if (tick_r != '0) tick_r <= tick_r - TICK_W'(1);
          else if (bit_r != BIT_STOP) begin
            bit_r  <= bit_r + 4'h1;
            tick_r <= period_ext - TICK_W'(1);
            out_r  <= char_bit(cur_char, bit_r + 4'h1);
          end else if (idx_r != last_idx) begin
            idx_r  <= idx_r + 2'h1;
            bit_r  <= BIT_START;
            tick_r <= period_ext - TICK_W'(1);
            out_r  <= ~LINE_IDLE;
          end else begin
            oe_r    <= 1'b0;
            out_r   <= LINE_IDLE;
            idx_r   <= '0;
            tick_r  <= wait_limit;
            state_r <= ctrl_r[RNW_BIT] ? HS_LISTEN : HS_IDLE;
            done_r  <= ~ctrl_r[RNW_BIT];
          end
        end
        HS_LISTEN: begin
          if (fall) begin
            state_r <= HS_RX;
            bit_r   <= BIT_START;
            tick_r  <= period_ext >> 1;
          end else if (tick_r == '0) begin
            state_r <= HS_IDLE;
            tout_r  <= (idx_r != 2'h2);
            done_r  <= 1'b1;
          end else tick_r <= tick_r - TICK_W'(1);
        end
        HS_RX: begin
          if (tick_r != '0) tick_r <= tick_r - TICK_W'(1);
          else if (bit_r != BIT_STOP) begin
            if (bit_r != BIT_START) shift_r <= {link.line, shift_r[8:1]};
            bit_r  <= bit_r + 4'h1;
            tick_r <= period_ext - TICK_W'(1);
          end else begin
            if (idx_r == '0) rdata_r[7:0] <= shift_r[7:0];
            else rdata_r[15:8] <= shift_r[7:0];
            if (shift_r[8] != ^shift_r[7:0] || link.line != LINE_IDLE) perr_r <= 1'b1;
            idx_r   <= idx_r + 2'h1;
            // After the last character stay busy one more bit, so the device's stop bit ends first
            tick_r  <= (idx_r == '0) ? wait_limit : period_ext;
            state_r <= HS_LISTEN;
          end
        end
        default: begin
          state_r <= HS_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  assign link.host_out = out_r;
  assign link.host_oe  = oe_r;
endmodule : otpu_host

//--- sim/otpu_link_properties.sv
`timescale 1ns/1ps
module otpu_link_properties #(
  parameter int BIT = 40
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Link wires
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic line
);
  int unsigned idle_cnt_r;
  logic        host_last_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Length of the current high stretch, to size the turnaround
  always_ff @(posedge ref_clk) begin
    idle_cnt_r <= (srst || !line) ? 0 : idle_cnt_r + 1;
  end
  // Host spoke last; only the first device drive after it is a turnaround
  always_ff @(posedge ref_clk) begin
    host_last_r <= srst ? 1'b0 : (host_oe && !host_out) ? 1'b1 : dev_oe ? 1'b0 : host_last_r;
  end
  a_reset_idle: assert property (disable iff (1'b0) srst |=> line && !dev_oe && !host_oe)
    else $error("line not idle after reset");
  a_pull_only: assert property (dev_oe |-> !dev_out)
    else $error("device drives line high");
  a_one_driver: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the line");
  a_low_bit_len: assert property ($fell(line) |=> !line [*8])
    else $error("low bit too short");
  a_high_bit_len: assert property ($rose(line) |=> line [*8])
    else $error("high bit too short");
  a_gap_floor: assert property (dev_oe && host_last_r |-> idle_cnt_r > 7 * BIT)
    else $error("answer before turnaround gap");
  a_gap_ceiling: assert property (dev_oe && host_last_r |-> idle_cnt_r < 18 * BIT)
    else $error("answer far too late");
  a_host_release_high: assert property ($fell(host_oe) |-> line)
    else $error("host released line while low");
  c_answer: cover property ($rose(dev_oe) && host_last_r);
  c_host_start: cover property ($rose(host_oe));
  c_long_idle: cover property (idle_cnt_r > 20 * BIT);
endmodule : otpu_link_properties

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import otpu_pkg::*;
  localparam int BIT = 40;
  logic                ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic                pready, pslverr, functional_mode, e, sy = 1;
  logic [7:0]          paddr = '0;
  logic [31:0]         pwdata = '0, prdata, r, st, seed = 60;
  logic [15:0]         angle_value = '0, d;
  logic [OTP_BITS-1:0] otp_image, img;
  logic [6:0]          a;
  int                  bad_count = 0, cmp_count = 0;

  otpu_link_if lk ();
  otpu_device #(.TIMEOUT_CYCLES(64 * BIT)) otpu_device_i (.ref_clk(ref_clk), .srst(srst), .link(lk),
    .angle_value(angle_value), .otp_image(otp_image), .functional_mode(functional_mode));
  otpu_host otpu_host_i (.ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  otpu_link_properties #(.BIT(BIT)) otpu_link_properties_i (.ref_clk(ref_clk), .srst(srst),
    .host_out(lk.host_out), .host_oe(lk.host_oe), .dev_out(lk.dev_out), .dev_oe(lk.dev_oe), .line(lk.line));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task end_sim();
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Full request, with sync only while sy is set; leaves STAT in st and DATA in r
  task xact(input logic [7:0] c, input logic [15:0] wd);
    apb(1, REG_DATA, {16'h0, wd});
    apb(1, REG_CTRL, {23'h0, sy, c});
    st = 1;
    for (int i = 0; i < 1500 && st[STAT_BUSY]; i++) begin
      apb(0, REG_STAT, 0);
      st = r;
    end
    if (st[STAT_BUSY]) begin
      bad_count++;
      $display("Error at %0t: request never finished", $time);
    end
    apb(0, REG_DATA, 0);
  endtask : xact

  // Watchdog sized well above the whole run
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 0;
    apb(1, REG_BAUD, BIT);
    apb(0, REG_BAUD, 0);
    chk(r, BIT);
    apb(0, 8'h10, 0);
    chk({31'h0, e}, 1);
    // Random user-region words, written then read back
    repeat (4) begin
      a = 7'(2 * (xs() % 7));
      d = 16'(xs());
      xact({1'b0, a}, d);
      chk(st[3:0], 4'h2);
      xact({1'b1, a}, 16'h0);
      chk(r[15:0], d);
      chk(otp_image[a * 8 +: 16], d);
    end
    angle_value <= 16'(xs());
    xact({1'b1, ADDR_ANGLE_LO}, 16'h0);
    chk(r[15:0], angle_value);
    // Unmapped device address takes no write
    img = otp_image;
    xact(8'h70, 16'hFFFF);
    chk(32'(otp_image == img), 1);
    xact(8'hF0, 16'h0);
    chk(r[15:0], 16'h0);
    // Manual bit period: later requests carry no sync character
    xact({1'b0, ADDR_BAUD_LO}, 16'(BIT));
    sy = 0;
    xact({1'b1, ADDR_BAUD_LO}, 16'h0);
    chk(r[15:0], BIT);
    xact({1'b0, ADDR_FUNC}, {8'h00, UNLOCK_KEY_DEFAULT});
    chk(32'(functional_mode), 1);
    // Functional mode ignores the line, so the host times out
    xact(8'h80, 16'h0);
    chk(32'(st[STAT_TOUT]), 1);
    // Power cycle back to blank fuses, then burn the user lock
    srst <= 1;
    repeat (20) @(posedge ref_clk);
    srst <= 0;
    sy = 1;
    apb(1, REG_BAUD, BIT);
    chk(32'(functional_mode), 0);
    xact(8'h0C, 16'h0100);
    xact({1'b0, ADDR_BURN}, {8'h00, UNLOCK_KEY_DEFAULT});
    chk(32'(functional_mode), 1);
    xact(8'h00, 16'hFFFF);
    chk(otp_image[15:0], 16'h0);
    end_sim();
  end
endmodule : testbench
